// ---- verilog/timer_pkg.sv ----
package timer_pkg;

	// Register byte addresses on the APB
	localparam logic [7:0] ADDR_WIDE_MODE  = 8'h00;
	localparam logic [7:0] ADDR_WIDE_COUNT = 8'h04;
	localparam logic [7:0] ADDR_SMALL_MODE = 8'h08;
	localparam logic [7:0] ADDR_FIRST      = 8'h0c;
	localparam logic [7:0] ADDR_SECOND     = 8'h10;
	localparam logic [7:0] ADDR_THIRD      = 8'h14;
	localparam logic [7:0] ADDR_FLAGS      = 8'h18;

	// Reset values
	localparam logic [7:0]  WIDE_MODE_RESET  = 8'h00;
	localparam logic [7:0]  SMALL_MODE_RESET = 8'h00;
	localparam logic [15:0] WIDE_COUNT_RESET = 16'h0000;
	localparam logic [7:0]  SMALL_RESET      = 8'h00;
	localparam logic [4:0]  FLAGS_RESET      = 5'h00;

	// Request flag positions in the flag register
	localparam int FLAG_WIDE_UF = 0;
	localparam int FLAG_EVENT   = 1;
	localparam int FLAG_FIRST   = 2;
	localparam int FLAG_SECOND  = 3;
	localparam int FLAG_THIRD   = 4;
	localparam int FLAG_W       = 5;

	// Prescaler width and the divide-by-eight code
	localparam int         PRESCALE_W = 6;
	localparam logic [1:0] PHI8_CODE  = 2'h0;

	// Operating modes of the wide counter
	typedef enum logic [1:0] {
		MODE_TIMER,
		MODE_PERIOD,
		MODE_EVENT,
		MODE_HL
	} wide_mode_e;

	// Wide counter mode register, bit 7 first
	typedef struct packed {
		logic       wide_counter_stop;
		logic       wide_edge_polarity;
		wide_mode_e mode;
		logic [1:0] div;
		logic       wide_toggle_output_enable;
		logic       wide_latch_only;
	} wide_mode_s;

	// Shared mode register of the three small timers, bit 7 first
	typedef struct packed {
		logic small_write_control;
		logic toggle_output_enable;
		logic toggle_start_polarity;
		logic third_small_source_select;
		logic second_small_source_select;
		logic first_small_source_select;
		logic spare;
		logic toggle_source_select;
	} small_mode_s;

	// One-cycle tick of the system clock divided by 8, 16, 32 or 64
	function automatic logic prescale_tick(input logic [PRESCALE_W-1:0] cnt, input logic [1:0] div);
		logic t;
		t = 1'b0;
		unique case (div)
			2'h0: t = &cnt[2:0];
			2'h1: t = &cnt[3:0];
			2'h2: t = &cnt[4:0];
			2'h3: t = &cnt[5:0];
		endcase
		return t;
	endfunction

endpackage

// ---- verilog/small_reload_timer.sv ----
`timescale 1ns/1ps
// Eight-bit down counter with its own reload latch
module small_reload_timer (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       tick,
	input  wire logic       wr_en,
	input  wire logic       latch_only,
	input  wire logic [7:0] wr_data,
	output logic      [7:0] count,
	output logic      [7:0] latch,
	output logic            underflow
);
	import timer_pkg::*;

	logic [7:0] count_q, count_d; // Live count
	logic [7:0] latch_q, latch_d; // Reload value

	// A write wins over a tick in the same cycle
	always_comb begin
		count_d = count_q;
		latch_d = latch_q;
		if (wr_en) begin
			latch_d = wr_data;
			if (!latch_only) begin
				count_d = wr_data;
			end
		end else if (tick) begin
			// Reload at zero gives a divide by n plus one
			count_d = (count_q == 8'h00) ? latch_q : count_q - 8'h01;
		end
	end

	// Registers only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= SMALL_RESET;
			latch_q <= SMALL_RESET;
		end else begin
			count_q <= count_d;
			latch_q <= latch_d;
		end
	end

	// Underflow is combinational so a cascaded timer sees it the same cycle
	assign underflow = tick && !wr_en && (count_q == 8'h00);
	assign count     = count_q;
	assign latch     = latch_q;

endmodule

// ---- verilog/timer_y_and_byte_timers.sv ----
// Summary of operation
// (R1) Stop bit freezes the wide counter; a counter write still loads it
// (R2) Timer mode counts prescaled clock /8../64
// (R3) Underflow sets flag, reloads, keeps counting
// (R4) Toggle drives event pin when enabled; the code drives it in timer mode only
// (R5) Toggle inverts per underflow, polarity sets start
// (R6) Period mode, polarity zero: falling edge captures
// (R7) Period mode, polarity one: rising edge captures
// (R8) Capture flags pin request; reads show capture
// (R9) Event mode counts selected pin edge
// (R10) HL mode captures on both pin edges
// (R11) Shared write bit: latch only or both
// (R12) Small toggle start level and enable
// (R13) First timer counts clock/8 or sub-clock/2
// (R14) Source select zero: toggle on first underflow
// (R15) Source select one: toggle on second underflow
// (R16) Second timer counts first underflow or clock
// (R17) Third timer counts first underflow or clock/8
// (R18) Third timer writes load counter and latch
// (R19) Source change leaves latch; software rewrites
// (R20) Three 8-bit counters with reload latches
// (R21) Loaded n divides source by n plus one
// (R22) Wide counter: 16-bit latch, four modes
`timescale 1ns/1ps
module timer_y_and_byte_timers (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        wide_event_pin_in,
	output logic             wide_event_pin_out,
	output logic             wide_event_pin_oe,
	input  wire logic        sub_clock_input,
	output logic             small_toggle_pin,
	output logic             small_toggle_oe,
	output logic [timer_pkg::FLAG_W-1:0] irq_flags
);
	import timer_pkg::*;

	// Bus slave state
	logic [31:0] prdata_q, prdata_d;   // Read data, sampled in setup
	logic        pready_q, pready_d;   // One wait-free access cycle
	logic        pslverr_q, pslverr_d; // Unmapped address answer
	logic        bus_wr;               // Write takes effect
	logic        addr_hit;             // Address maps to a register

	// Mode registers
	wide_mode_s  wide_mode_q, wide_mode_d;
	small_mode_s small_mode_q, small_mode_d;

	// Wide counter state
	logic [15:0] wide_count_q, wide_count_d;     // Live count
	logic [15:0] wide_latch_q, wide_latch_d;     // Reload latch
	logic [15:0] wide_capture_q, wide_capture_d; // Captured value
	logic        wide_toggle_q, wide_toggle_d;   // Toggle signal
	logic        wide_oe_q, wide_oe_d;           // Pin driven
	logic        wide_tick;                      // Count enable
	logic        cap_edge;                       // Capturing edge
	logic        wide_uf;                        // Underflow event
	logic        wide_wr;                        // Counter write
	logic        toggle_live;                    // Toggle may run

	// Clock sources and edge detectors
	logic [PRESCALE_W-1:0] pre_q, pre_d; // Free prescaler
	logic pin_prev_q, pin_prev_d;        // Last event pin level
	logic sub_prev_q, sub_prev_d;        // Last sub-clock level
	logic sub_half_q, sub_half_d;        // Sub-clock divide by two
	logic pin_rise, pin_fall;
	logic phi8_tick, sub_tick;

	// Small timers
	logic [7:0] t1_count, t2_count, t3_count;
	logic [7:0] t1_latch, t2_latch, t3_latch;
	logic       t1_tick, t2_tick, t3_tick;
	logic       t1_uf, t2_uf, t3_uf;
	logic       t1_wr, t2_wr, t3_wr;
	logic       small_tog_q, small_tog_d; // Small toggle level
	logic       small_oe_q, small_oe_d;   // Small pin driven

	// Request flags
	logic [FLAG_W-1:0] flags_q, flags_d;
	logic [FLAG_W-1:0] flag_set, flag_clr;

	// Decode of mapped addresses
	function automatic logic mapped(input logic [7:0] a);
		return a == ADDR_WIDE_MODE || a == ADDR_WIDE_COUNT || a == ADDR_SMALL_MODE ||
			a == ADDR_FIRST || a == ADDR_SECOND || a == ADDR_THIRD || a == ADDR_FLAGS;
	endfunction

	assign addr_hit = mapped(paddr);
	assign bus_wr   = psel && penable && pready_q && pwrite && addr_hit;
	assign wide_wr  = bus_wr && paddr == ADDR_WIDE_COUNT;
	assign t1_wr    = bus_wr && paddr == ADDR_FIRST;
	assign t2_wr    = bus_wr && paddr == ADDR_SECOND;
	assign t3_wr    = bus_wr && paddr == ADDR_THIRD;

	// Bus answer: read data is sampled in setup so it comes from a flop
	always_comb begin
		pready_d  = psel && !penable;
		pslverr_d = psel && !penable && !addr_hit;
		prdata_d  = prdata_q;
		if (psel && !penable) begin
			prdata_d = 32'h0000_0000;
			unique case (paddr)
				ADDR_WIDE_MODE:  prdata_d[7:0] = wide_mode_q;
				ADDR_WIDE_COUNT: begin
					// Measurement modes show the captured value
					if (wide_mode_q.mode == MODE_PERIOD || wide_mode_q.mode == MODE_HL) begin
						prdata_d[15:0] = wide_capture_q; // R8
					end else begin
						prdata_d[15:0] = wide_count_q;
					end
				end
				ADDR_SMALL_MODE: prdata_d[7:0] = small_mode_q;
				ADDR_FIRST:      prdata_d[7:0] = t1_count;
				ADDR_SECOND:     prdata_d[7:0] = t2_count;
				ADDR_THIRD:      prdata_d[7:0] = t3_count;
				ADDR_FLAGS:      prdata_d[FLAG_W-1:0] = flags_q;
				default:         prdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Mode register writes
	always_comb begin
		wide_mode_d  = wide_mode_q;
		small_mode_d = small_mode_q;
		if (bus_wr && paddr == ADDR_WIDE_MODE) begin
			wide_mode_d = pwdata[7:0]; // R22
		end
		if (bus_wr && paddr == ADDR_SMALL_MODE) begin
			small_mode_d = pwdata[7:0];
		end
	end

	// Clock sources: prescaler, pin edges, sub-clock halving
	always_comb begin
		pre_d      = pre_q + 1'b1;
		pin_prev_d = wide_event_pin_in;
		sub_prev_d = sub_clock_input;
		sub_half_d = sub_half_q ^ (sub_clock_input && !sub_prev_q);
	end
	assign pin_rise  = wide_event_pin_in && !pin_prev_q;
	assign pin_fall  = !wide_event_pin_in && pin_prev_q;
	assign phi8_tick = prescale_tick(pre_q, PHI8_CODE);
	// Every second sub-clock rising edge
	assign sub_tick  = sub_clock_input && !sub_prev_q && sub_half_q; // R13

	// Wide counter count source and capture edge per mode
	always_comb begin
		wide_tick = 1'b0;
		cap_edge  = 1'b0;
		unique case (wide_mode_q.mode)
			MODE_TIMER:  wide_tick = prescale_tick(pre_q, wide_mode_q.div); // R2
			MODE_PERIOD: begin
				wide_tick = prescale_tick(pre_q, wide_mode_q.div);
				cap_edge  = wide_mode_q.wide_edge_polarity ? pin_rise : pin_fall; // R6 R7
			end
			MODE_EVENT:  wide_tick = wide_mode_q.wide_edge_polarity ? pin_fall : pin_rise; // R9
			MODE_HL: begin
				wide_tick = prescale_tick(pre_q, wide_mode_q.div);
				cap_edge  = pin_rise || pin_fall; // R10
			end
		endcase
	end

	// Stop freezes count; a capture wins over a tick
	assign wide_uf = !wide_wr && !wide_mode_q.wide_counter_stop && !cap_edge &&
		wide_tick && wide_count_q == 16'h0000;
	assign toggle_live = wide_mode_q.mode == MODE_TIMER && wide_mode_q.wide_toggle_output_enable;

	// Wide counter next state
	always_comb begin
		wide_count_d   = wide_count_q;
		wide_latch_d   = wide_latch_q;
		wide_capture_d = wide_capture_q;
		if (cap_edge) begin
			wide_capture_d = wide_count_q; // R6 R7 R10
		end
		if (wide_wr) begin
			wide_latch_d = pwdata[15:0]; // R22
			if (!wide_mode_q.wide_latch_only) begin
				wide_count_d = pwdata[15:0];
			end
		end else if (wide_mode_q.wide_counter_stop) begin
			wide_count_d = wide_count_q; // R1
		end else if (cap_edge) begin
			wide_count_d = wide_latch_q; // R6 R7 R10
		end else if (wide_tick) begin
			// Reload on underflow, else step down
			wide_count_d = wide_uf ? wide_latch_q : wide_count_q - 16'h0001; // R3 R21
		end
	end

	// Wide toggle: held at its start level until it may run
	// Start level follows the incoming mode so one write can set polarity and enable
	always_comb begin
		wide_oe_d = toggle_live; // R4
		if (!toggle_live) begin
			wide_toggle_d = !wide_mode_d.wide_edge_polarity; // R5
		end else if (wide_uf) begin
			wide_toggle_d = !wide_toggle_q; // R5
		end else begin
			wide_toggle_d = wide_toggle_q;
		end
	end

	// Small timer count sources
	assign t1_tick = small_mode_q.first_small_source_select ? sub_tick : phi8_tick; // R13
	assign t2_tick = small_mode_q.second_small_source_select ? 1'b1 : t1_uf; // R16
	assign t3_tick = small_mode_q.third_small_source_select ? phi8_tick : t1_uf; // R17

	// Three identical counters, source changes never touch a latch
	small_reload_timer u_first ( // R20 R19
		.pclk      (pclk),
		.presetn   (presetn),
		.tick      (t1_tick),
		.wr_en     (t1_wr),
		.latch_only(small_mode_q.small_write_control), // R11
		.wr_data   (pwdata[7:0]),
		.count     (t1_count),
		.latch     (t1_latch),
		.underflow (t1_uf)
	);
	small_reload_timer u_second (
		.pclk      (pclk),
		.presetn   (presetn),
		.tick      (t2_tick),
		.wr_en     (t2_wr),
		.latch_only(small_mode_q.small_write_control), // R11
		.wr_data   (pwdata[7:0]),
		.count     (t2_count),
		.latch     (t2_latch),
		.underflow (t2_uf)
	);
	small_reload_timer u_third (
		.pclk      (pclk),
		.presetn   (presetn),
		.tick      (t3_tick),
		.wr_en     (t3_wr),
		.latch_only(1'b0), // R18
		.wr_data   (pwdata[7:0]),
		.count     (t3_count),
		.latch     (t3_latch),
		.underflow (t3_uf)
	);

	// Small toggle follows the selected timer's underflows
	always_comb begin
		small_oe_d = small_mode_q.toggle_output_enable; // R12
		if (!small_mode_q.toggle_output_enable) begin
			small_tog_d = !small_mode_d.toggle_start_polarity; // R12
		end else if (small_mode_q.toggle_source_select ? t2_uf : t1_uf) begin
			small_tog_d = !small_tog_q; // R14 R15
		end else begin
			small_tog_d = small_tog_q;
		end
	end

	// Request flags: write one clears, a same-cycle set wins
	always_comb begin
		flag_set               = '0;
		flag_set[FLAG_WIDE_UF] = wide_uf; // R3
		flag_set[FLAG_EVENT]   = cap_edge; // R8
		flag_set[FLAG_FIRST]   = t1_uf; // R3
		flag_set[FLAG_SECOND]  = t2_uf;
		flag_set[FLAG_THIRD]   = t3_uf;
		flag_clr = (bus_wr && paddr == ADDR_FLAGS) ? pwdata[FLAG_W-1:0] : '0;
		flags_d  = (flags_q & ~flag_clr) | flag_set;
	end

	// All registers of the top level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q       <= 32'h0000_0000;
			pready_q       <= 1'b0;
			pslverr_q      <= 1'b0;
			wide_mode_q    <= WIDE_MODE_RESET;
			small_mode_q   <= SMALL_MODE_RESET;
			wide_count_q   <= WIDE_COUNT_RESET;
			wide_latch_q   <= WIDE_COUNT_RESET;
			wide_capture_q <= WIDE_COUNT_RESET;
			wide_toggle_q  <= 1'b1;
			wide_oe_q      <= 1'b0;
			pre_q          <= '0;
			pin_prev_q     <= 1'b0;
			sub_prev_q     <= 1'b0;
			sub_half_q     <= 1'b0;
			small_tog_q    <= 1'b1;
			small_oe_q     <= 1'b0;
			flags_q        <= FLAGS_RESET;
		end else begin
			prdata_q       <= prdata_d;
			pready_q       <= pready_d;
			pslverr_q      <= pslverr_d;
			wide_mode_q    <= wide_mode_d;
			small_mode_q   <= small_mode_d;
			wide_count_q   <= wide_count_d;
			wide_latch_q   <= wide_latch_d;
			wide_capture_q <= wide_capture_d;
			wide_toggle_q  <= wide_toggle_d;
			wide_oe_q      <= wide_oe_d;
			pre_q          <= pre_d;
			pin_prev_q     <= pin_prev_d;
			sub_prev_q     <= sub_prev_d;
			sub_half_q     <= sub_half_d;
			small_tog_q    <= small_tog_d;
			small_oe_q     <= small_oe_d;
			flags_q        <= flags_d;
		end
	end

	assign prdata             = prdata_q;
	assign pready             = pready_q;
	assign pslverr            = pslverr_q;
	assign wide_event_pin_out = wide_toggle_q;
	assign wide_event_pin_oe  = wide_oe_q;
	assign small_toggle_pin   = small_tog_q;
	assign small_toggle_oe    = small_oe_q;
	assign irq_flags          = flags_q;

	// Checks on the counting logic
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// A capture is an edge, then copy and reload one cycle later
	sequence s_capture;
		cap_edge && !wide_wr && !wide_mode_q.wide_counter_stop;
	endsequence
	sequence s_captured(logic [15:0] c, logic [15:0] l);
		wide_capture_q == c && wide_count_q == l && flags_q[FLAG_EVENT];
	endsequence

	a_stop_holds_count: assert property ( // R1
		wide_mode_q.wide_counter_stop && !wide_wr |=> wide_count_q == $past(wide_count_q))
		else $error("wide counter moved while stopped");
	a_underflow_reload: assert property ( // R3
		wide_uf |=> wide_count_q == $past(wide_latch_q) && flags_q[FLAG_WIDE_UF])
		else $error("wide underflow did not reload and flag");
	a_toggle_pin_enable: assert property ( // R4
		1'b1 |=> wide_event_pin_oe == $past(toggle_live))
		else $error("event pin drive does not follow enable");
	a_toggle_inverts: assert property ( // R5
		wide_uf && toggle_live |=> wide_event_pin_out != $past(wide_event_pin_out))
		else $error("toggle did not invert on underflow");
	a_capture_reload: assert property ( // R6
		s_capture |=> s_captured($past(wide_count_q), $past(wide_latch_q)))
		else $error("capture edge did not copy and reload");
	a_period_edge_pick: assert property ( // R7
		wide_mode_q.mode == MODE_PERIOD && pin_rise |-> cap_edge == wide_mode_q.wide_edge_polarity)
		else $error("period mode captured on the wrong edge");
	a_event_counts: assert property ( // R9
		wide_mode_q.mode == MODE_EVENT && !wide_mode_q.wide_counter_stop && !wide_wr &&
		(wide_mode_q.wide_edge_polarity ? pin_fall : pin_rise) && wide_count_q != 16'h0000
		|=> wide_count_q == $past(wide_count_q) - 16'h0001)
		else $error("event edge did not decrement");
	a_latch_only_write: assert property ( // R11
		t1_wr && small_mode_q.small_write_control && !t1_tick
		|=> t1_latch == $past(pwdata[7:0]) && t1_count == $past(t1_count))
		else $error("latch-only write disturbed the first counter");
	a_third_loads_both: assert property ( // R18
		t3_wr |=> t3_count == $past(pwdata[7:0]) && t3_latch == $past(pwdata[7:0]))
		else $error("third timer write did not load both");
	a_small_toggle_src: assert property ( // R15
		small_mode_q.toggle_output_enable && small_mode_q.toggle_source_select && t2_uf
		|=> small_toggle_pin != $past(small_toggle_pin))
		else $error("small toggle missed second underflow");

endmodule

// ---- tb/pin_partner.sv ----
`timescale 1ns/1ps
// Far side of the pins: event waveform source and sub-clock source
module pin_partner (
	input  wire logic       pclk,
	input  wire logic       evt_run,
	input  wire logic [7:0] evt_half,
	input  wire logic       sub_run,
	input  wire logic       dev_out,
	input  wire logic       dev_oe,
	output logic            pin_level,
	output logic            sub_clk
);
	logic       wave = 1'b0;  // Event waveform level
	logic [7:0] cnt  = 8'h00; // Cycles into the half period
	logic [1:0] scnt = 2'h0;  // Sub-clock phase

	// Device drive wins while its enable is up
	assign pin_level = dev_oe ? dev_out : wave;

	// Square wave while running, back to idle low when stopped
	always @(posedge pclk) begin
		if (!evt_run) begin
			wave <= 1'b0;
			cnt  <= 8'h00;
		end else if (cnt == evt_half - 8'h01) begin
			wave <= ~wave;
			cnt  <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end

	// Sub-clock of six pclk periods; stands low when not running
	always @(posedge pclk) begin
		if (!sub_run) begin
			sub_clk <= 1'b0;
			scnt    <= 2'h0;
		end else if (scnt == 2'h2) begin
			sub_clk <= ~sub_clk;
			scnt    <= 2'h0;
		end else begin
			scnt <= scnt + 2'h1;
		end
	end
endmodule

// ---- tb/timer_y_and_byte_timers_bench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, (a), (b)); end end
module timer_y_and_byte_timers_bench;
	import timer_pkg::*;
	logic              pclk, presetn, psel, penable, pwrite;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic              pready, pslverr, err;
	logic              ev_out, ev_oe, pin, sub_clk, tog, tog_oe;
	logic              evt_run, sub_run, cnt_en, prev_pin;
	logic [7:0]        evt_half;
	logic [15:0]       sv;
	logic [FLAG_W-1:0] flags;
	int                n_mismatch, cmp_count, n_rise, n_fall, m, h;

	// 50 MHz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	timer_y_and_byte_timers u_timer_y_and_byte_timers (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wide_event_pin_in(pin), .wide_event_pin_out(ev_out), .wide_event_pin_oe(ev_oe),
		.sub_clock_input(sub_clk), .small_toggle_pin(tog), .small_toggle_oe(tog_oe), .irq_flags(flags)
	);
	pin_partner u_pin_partner (
		.pclk(pclk), .evt_run(evt_run), .evt_half(evt_half), .sub_run(sub_run),
		.dev_out(ev_out), .dev_oe(ev_oe), .pin_level(pin), .sub_clk(sub_clk)
	);

	// Edge tally of the event pin, sampled as the design samples it
	always @(posedge pclk) begin
		prev_pin <= pin;
		if (cnt_en && pin && !prev_pin) n_rise++;
		if (cnt_en && !pin && prev_pin) n_fall++;
	end

	// One APB transfer; result lands in rd and err
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			n_mismatch++;
			finish_test();
		end
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Cycles between two changes of a toggle output (0 wide, 1 small)
	task automatic meas(input int sel, output int c);
		logic l;
		for (int i = 0; i < 2; i++) begin
			l = sel ? tog : ev_out;
			c = 0;
			while ((sel ? tog : ev_out) === l && c < 40000) begin
				@(posedge pclk);
				c++;
			end
		end
		if (c >= 40000) begin
			n_mismatch++;
			finish_test();
		end
	endtask

	// Single exit point with the verdict
	task automatic finish_test();
		$display("mismatches %0d of %0d compares", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		presetn    = 1'b0;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 8'h00;
		pwdata     = 32'h0;
		evt_run    = 1'b0;
		evt_half   = 8'h20;
		sub_run    = 1'b0;
		cnt_en     = 1'b0;
		n_rise     = 0;
		n_fall     = 0;
		n_mismatch = 0;
		cmp_count  = 0;
		m = $urandom(6495);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// Small mode reset value, then an unmapped word is refused
		apb(1'b0, ADDR_SMALL_MODE, 32'h0);
		`CHK(rd[7:0], SMALL_MODE_RESET)
		apb(1'b0, 8'h1c, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		// Wide timer mode: every divider, both start levels
		for (int dv = 0; dv < 4; dv++) begin
			m = $urandom_range(7, 1);
			apb(1'b1, ADDR_WIDE_MODE, 32'h80);
			apb(1'b1, ADDR_WIDE_COUNT, m);
			apb(1'b1, ADDR_WIDE_MODE, {24'h0, 1'b0, dv[0], 2'h0, dv[1:0], 2'h2});
			repeat (2) @(posedge pclk);
			`CHK({ev_oe, ev_out}, {1'b1, ~dv[0]})
			meas(0, h);
			`CHK(h, (m + 1) * (8 << dv))
		end
		`CHK(flags[FLAG_WIDE_UF], 1'b1)
		// Stop bit freezes the count
		apb(1'b1, ADDR_WIDE_MODE, 32'h80);
		apb(1'b0, ADDR_WIDE_COUNT, 32'h0);
		sv = rd[15:0];
		repeat (100) @(posedge pclk);
		apb(1'b0, ADDR_WIDE_COUNT, 32'h0);
		`CHK(rd[15:0], sv)
		// Period (both polarities) and high/low capture, 64-cycle waveform
		apb(1'b1, ADDR_WIDE_COUNT, 32'd100);
		evt_run <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, ADDR_WIDE_MODE, {24'h0, 1'b0, k != 0, (k == 2) ? 2'h3 : 2'h1, 4'h0});
			apb(1'b1, ADDR_FLAGS, 32'h1f);
			repeat (200) @(posedge pclk);
			h = (k == 2) ? 96 : 92;
			apb(1'b0, ADDR_WIDE_COUNT, 32'h0);
			`CHK((rd[15:0] >= h - 1) && (rd[15:0] <= h + 1), 1'b1)
			repeat (10) @(posedge pclk);
			apb(1'b0, ADDR_WIDE_COUNT, 32'h0);
			`CHK((rd[15:0] >= h - 1) && (rd[15:0] <= h + 1), 1'b1)
			`CHK({flags[FLAG_EVENT], ev_oe}, 2'h2)
		end
		// Event counting on the selected edge
		evt_half <= 8'h04;
		for (int p = 0; p < 2; p++) begin
			evt_run <= 1'b0;
			apb(1'b1, ADDR_WIDE_MODE, {24'h0, 1'b0, p[0], 2'h2, 4'h0});
			apb(1'b1, ADDR_WIDE_COUNT, 32'd200);
			n_rise = 0;
			n_fall = 0;
			cnt_en  <= 1'b1;
			evt_run <= 1'b1;
			repeat (80) @(posedge pclk);
			evt_run <= 1'b0;
			repeat (4) @(posedge pclk);
			cnt_en <= 1'b0;
			apb(1'b0, ADDR_WIDE_COUNT, 32'h0);
			`CHK(rd[15:0], 16'd200 - 16'(p ? n_fall : n_rise))
		end
		// First small timer on clock/8, both start levels
		for (int p = 0; p < 2; p++) begin
			m = $urandom_range(7, 1);
			apb(1'b1, ADDR_FIRST, 32'd200);
			apb(1'b1, ADDR_SMALL_MODE, {24'h0, 2'h0, p[0], 5'h0});
			repeat (2) @(posedge pclk);
			`CHK({tog_oe, tog}, {1'b0, ~p[0]})
			apb(1'b1, ADDR_SMALL_MODE, {24'h0, 2'h1, p[0], 5'h0});
			repeat (2) @(posedge pclk);
			`CHK({tog_oe, tog}, {1'b1, ~p[0]})
			apb(1'b1, ADDR_FIRST, m);
			meas(1, h);
			`CHK(h, (m + 1) * 8)
		end
		// Sub-clock source, timer rewritten after the switch
		sub_run <= 1'b1;
		apb(1'b1, ADDR_SMALL_MODE, 32'h44);
		apb(1'b1, ADDR_FIRST, m);
		meas(1, h);
		`CHK(h, (m + 1) * 12)
		// Second timer on pclk, then on first-timer underflows
		apb(1'b1, ADDR_SMALL_MODE, 32'h49);
		apb(1'b1, ADDR_SECOND, m);
		meas(1, h);
		`CHK(h, m + 1)
		apb(1'b1, ADDR_SMALL_MODE, 32'h41);
		apb(1'b1, ADDR_FIRST, 32'd3);
		apb(1'b1, ADDR_SECOND, m);
		meas(1, h);
		`CHK(h, (m + 1) * 32)
		// Latch-only write lands at the next underflow
		apb(1'b1, ADDR_SMALL_MODE, 32'h40);
		apb(1'b1, ADDR_FIRST, 32'd200);
		apb(1'b1, ADDR_SMALL_MODE, 32'hc0);
		apb(1'b1, ADDR_FIRST, 32'd5);
		apb(1'b0, ADDR_FIRST, 32'h0);
		`CHK(rd[7:0] > 8'd150, 1'b1)
		meas(1, h);
		`CHK(h, 48)
		// Third timer always loads the counter, then runs on clock/8
		apb(1'b1, ADDR_THIRD, 32'h5a);
		apb(1'b0, ADDR_THIRD, 32'h0);
		`CHK(rd[7:0] >= 8'h59 && rd[7:0] <= 8'h5a, 1'b1)
		apb(1'b1, ADDR_SMALL_MODE, 32'hd0);
		apb(1'b1, ADDR_THIRD, 32'h40);
		repeat (80) @(posedge pclk);
		apb(1'b0, ADDR_THIRD, 32'h0);
		`CHK(rd[7:0] >= 8'h35 && rd[7:0] <= 8'h37, 1'b1)
		`CHK(flags[FLAG_FIRST], 1'b1)
		finish_test();
	end
endmodule
